// ### shared/sdc_pkg.sv
package sdc_pkg;
  // ------------------------------------------------------------
  // Command encoding on {chip_sel_n, row_strobe_n, col_strobe_n, wr_en_n}
  // ------------------------------------------------------------
  localparam logic [3:0] SDC_ENC_NOP = 4'h7;
  localparam logic [3:0] SDC_ENC_BST = 4'h6;
  localparam logic [3:0] SDC_ENC_READ = 4'h5;
  localparam logic [3:0] SDC_ENC_STORE = 4'h4;
  localparam logic [3:0] SDC_ENC_ROW_OPEN = 4'h3;
  localparam logic [3:0] SDC_ENC_ROW_CLOSE = 4'h2;
  localparam logic [3:0] SDC_ENC_REFRESH = 4'h1;
  localparam logic [3:0] SDC_ENC_CFG_LOAD = 4'h0;

  localparam int SDC_ADDR_W = 12;
  localparam int SDC_BANK_BIT = 11;
  localparam int SDC_AUTOPRE_BIT = 10;
  localparam int SDC_COL_W = 8;
  localparam int SDC_BL_LSB = 0;
  localparam logic [2:0] SDC_BL_FULL_PAGE = 3'h7;
  localparam logic [11:0] SDC_CFG_RESET = 12'h000;

  // ------------------------------------------------------------
  // Timing, in ns, and cycle counts at the 40 MHz system clock
  // ------------------------------------------------------------
  localparam int SDC_CLK_PERIOD_NS = 25;
  localparam int SDC_T_ACT_TO_COL_NS = 20;
  localparam int SDC_T_WR_RECOVERY_NS = 14;
  localparam int SDC_T_WR_AUTOPRE_NS = 50;
  localparam int SDC_T_ROW_CYCLE_NS = 70;
  localparam int SDC_T_CFG_TO_CMD_NS = 28;

  function automatic int sdc_ceil_cyc(input int ns);
    int c;
    c = (ns + SDC_CLK_PERIOD_NS - 1) / SDC_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : sdc_ceil_cyc

  localparam int SDC_CYC_ACT_TO_COL = sdc_ceil_cyc(SDC_T_ACT_TO_COL_NS);
  localparam int SDC_CYC_WR_RECOVERY = sdc_ceil_cyc(SDC_T_WR_RECOVERY_NS);
  localparam int SDC_CYC_WR_AUTOPRE = sdc_ceil_cyc(SDC_T_WR_AUTOPRE_NS);
  localparam int SDC_CYC_ROW_CYCLE = sdc_ceil_cyc(SDC_T_ROW_CYCLE_NS);
  localparam int SDC_CYC_CFG_TO_CMD = sdc_ceil_cyc(SDC_T_CFG_TO_CMD_NS);
  localparam int SDC_CNT_W = 4;

  typedef enum {
    SDC_CMD_DESELECT, SDC_CMD_NO_OP, SDC_CMD_BURST_STOP, SDC_CMD_READ, SDC_CMD_STORE,
    SDC_CMD_ROW_OPEN, SDC_CMD_ROW_CLOSE, SDC_CMD_REFRESH, SDC_CMD_CFG_LOAD
  } sdc_cmd_e;

  typedef enum {
    SDC_BK_IDLE, SDC_BK_OPENING, SDC_BK_ACTIVE, SDC_BK_WR_REC, SDC_BK_WR_REC_AP,
    SDC_BK_REFRESH, SDC_BK_CFG, SDC_BK_POWER_DOWN, SDC_BK_RETAIN
  } sdc_bank_e;

  typedef struct packed {
    logic chip_sel_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic wr_en_n;
    logic clk_gate;
    logic [SDC_ADDR_W-1:0] addr;
  } sdc_pins_s;

  typedef struct packed {
    logic read_start;
    logic store_start;
    logic burst_stop;
    logic autopre;
    logic bank;
    logic [SDC_COL_W-1:0] col;
  } sdc_issue_s;
endpackage : sdc_pkg

// ### rtl/sdc_cmd_decode.sv
`timescale 1ns/10ps
module sdc_cmd_decode
  import sdc_pkg::*;
(
  input wire logic [3:0] pins_in, // Synchronised {cs_n, ras_n, cas_n, we_n}.
  output sdc_cmd_e cmd_out // Decoded command.
);
  always_comb begin
    if (pins_in[3]) begin
      cmd_out = SDC_CMD_DESELECT;
    end else begin
      case (pins_in)
        SDC_ENC_NOP: cmd_out = SDC_CMD_NO_OP;
        SDC_ENC_BST: cmd_out = SDC_CMD_BURST_STOP;
        SDC_ENC_READ: cmd_out = SDC_CMD_READ;
        SDC_ENC_STORE: cmd_out = SDC_CMD_STORE;
        SDC_ENC_ROW_OPEN: cmd_out = SDC_CMD_ROW_OPEN;
        SDC_ENC_ROW_CLOSE: cmd_out = SDC_CMD_ROW_CLOSE;
        SDC_ENC_REFRESH: cmd_out = SDC_CMD_REFRESH;
        default: cmd_out = SDC_CMD_CFG_LOAD;
      endcase
    end
  end
endmodule : sdc_cmd_decode

// ### rtl/sdc_cmd_state.sv
`timescale 1ns/10ps
module sdc_cmd_state
  import sdc_pkg::*;
#(
  parameter int BURST_LEN = 4 // Write burst length in cycles for non-full-page modes.
)(
  input wire logic clk_sys_in, // 40 MHz system clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire sdc_pins_s pins_in, // Command, address and clock-gate pins.
  output sdc_issue_s issue_out, // Accepted column command, one-cycle pulse.
  output logic [SDC_ADDR_W-1:0] cfg_out, // Configuration register.
  output sdc_bank_e bank0_state_out, // Bank 0 state.
  output sdc_bank_e bank1_state_out, // Bank 1 state.
  output logic illegal_out, // Illegal command seen, one-cycle pulse.
  output logic low_power_out // Power-down or retention active.
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  sdc_pins_s meta_r, pins_r, meta_nxt;
  always_comb begin
    meta_nxt = pins_in;
  end
  always_ff @(posedge clk_sys_in) begin
    meta_r <= meta_nxt;
    pins_r <= meta_r;
  end

  sdc_cmd_e cmd;
  sdc_cmd_decode u_dec (
    .pins_in({pins_r.chip_sel_n, pins_r.row_strobe_n, pins_r.col_strobe_n, pins_r.wr_en_n}),
    .cmd_out(cmd)
  );

  // ------------------------------------------------------------
  // Bank state machines
  // ------------------------------------------------------------
  sdc_bank_e st_r [2];
  sdc_bank_e st_nxt [2];
  logic [SDC_CNT_W-1:0] cnt_r [2];
  logic [SDC_CNT_W-1:0] cnt_nxt [2];
  logic [SDC_CNT_W-1:0] burst_r [2];
  logic [SDC_CNT_W-1:0] burst_nxt [2];
  logic ap_r [2];
  logic ap_nxt [2];
  logic [SDC_ADDR_W-1:0] cfg_r, cfg_nxt;
  sdc_issue_s issue_r, issue_nxt;
  logic illegal_r, illegal_nxt;
  logic lowp_r, lowp_nxt;
  logic gate_prev_r;
  logic sel;
  logic both_idle;
  logic full_page;

  function automatic logic [SDC_CNT_W-1:0] cyc(input int n);
    return SDC_CNT_W'(n - 1);
  endfunction : cyc

  always_comb begin
    sel = pins_r.addr[SDC_BANK_BIT];
    both_idle = (st_r[0] == SDC_BK_IDLE) && (st_r[1] == SDC_BK_IDLE);
    full_page = cfg_r[SDC_BL_LSB +: 3] == SDC_BL_FULL_PAGE;
    for (int b = 0; b < 2; b++) begin
      st_nxt[b] = st_r[b];
      cnt_nxt[b] = (cnt_r[b] != '0) ? cnt_r[b] - 1'b1 : cnt_r[b];
      burst_nxt[b] = (burst_r[b] != '0) ? burst_r[b] - 1'b1 : burst_r[b];
      ap_nxt[b] = ap_r[b];
    end
    cfg_nxt = cfg_r;
    issue_nxt = '0;
    illegal_nxt = 1'b0;
    lowp_nxt = lowp_r;
    if (lowp_r) begin
      // Only the clock gate is watched while asleep; all other pins are ignored.
      if (pins_r.clk_gate) begin
        lowp_nxt = 1'b0;
        st_nxt[0] = SDC_BK_IDLE;
        st_nxt[1] = SDC_BK_IDLE;
      end
    end else if (!pins_r.clk_gate && gate_prev_r && both_idle) begin
      lowp_nxt = 1'b1;
      // Refresh with the gate falling selects retention, otherwise power-down.
      st_nxt[0] = (cmd == SDC_CMD_REFRESH) ? SDC_BK_RETAIN : SDC_BK_POWER_DOWN;
      st_nxt[1] = (cmd == SDC_CMD_REFRESH) ? SDC_BK_RETAIN : SDC_BK_POWER_DOWN;
    end else begin
      for (int b = 0; b < 2; b++) begin
        // Timed transient states expire when their counter reaches zero.
        if (cnt_r[b] == '0) begin
          case (st_r[b])
            SDC_BK_OPENING: st_nxt[b] = SDC_BK_ACTIVE;
            SDC_BK_WR_REC: st_nxt[b] = SDC_BK_ACTIVE;
            SDC_BK_WR_REC_AP: st_nxt[b] = SDC_BK_IDLE;
            SDC_BK_REFRESH: st_nxt[b] = SDC_BK_IDLE;
            SDC_BK_CFG: st_nxt[b] = SDC_BK_IDLE;
            default: st_nxt[b] = st_r[b];
          endcase
        end
        // A finished write burst enters recovery; auto-precharge closes the row after it.
        if (st_r[b] == SDC_BK_ACTIVE && burst_r[b] == SDC_CNT_W'(1)) begin
          st_nxt[b] = ap_r[b] ? SDC_BK_WR_REC_AP : SDC_BK_WR_REC;
          cnt_nxt[b] = ap_r[b] ? cyc(SDC_CYC_WR_AUTOPRE) : cyc(SDC_CYC_WR_RECOVERY);
        end
      end
      case (cmd)
        SDC_CMD_DESELECT, SDC_CMD_NO_OP: begin
        end
        SDC_CMD_BURST_STOP: begin
          if (full_page) begin
            issue_nxt.burst_stop = 1'b1;
            for (int b = 0; b < 2; b++) begin
              if (st_r[b] == SDC_BK_ACTIVE) begin
                burst_nxt[b] = '0;
              end
            end
          end
        end
        SDC_CMD_READ, SDC_CMD_STORE: begin
          if (st_r[sel] == SDC_BK_ACTIVE || st_r[sel] == SDC_BK_WR_REC) begin
            issue_nxt.read_start = cmd == SDC_CMD_READ;
            issue_nxt.store_start = cmd == SDC_CMD_STORE;
            issue_nxt.autopre = pins_r.addr[SDC_AUTOPRE_BIT];
            issue_nxt.bank = sel;
            issue_nxt.col = pins_r.addr[SDC_COL_W-1:0];
            st_nxt[sel] = SDC_BK_ACTIVE;
            ap_nxt[sel] = pins_r.addr[SDC_AUTOPRE_BIT];
            if (cmd == SDC_CMD_STORE) begin
              burst_nxt[sel] = full_page ? '0 : SDC_CNT_W'(BURST_LEN);
            end else begin
              burst_nxt[sel] = '0;
              st_nxt[sel] = pins_r.addr[SDC_AUTOPRE_BIT] ? SDC_BK_IDLE : SDC_BK_ACTIVE;
            end
          end else begin
            illegal_nxt = 1'b1;
          end
        end
        SDC_CMD_ROW_OPEN: begin
          if (st_r[sel] == SDC_BK_IDLE) begin
            st_nxt[sel] = SDC_BK_OPENING;
            cnt_nxt[sel] = cyc(SDC_CYC_ACT_TO_COL);
          end else begin
            illegal_nxt = 1'b1;
          end
        end
        SDC_CMD_ROW_CLOSE: begin
          for (int b = 0; b < 2; b++) begin
            if (pins_r.addr[SDC_AUTOPRE_BIT] || sel == b[0]) begin
              if (st_r[b] == SDC_BK_ACTIVE) begin
                st_nxt[b] = SDC_BK_IDLE;
                burst_nxt[b] = '0;
              end else if (st_r[b] != SDC_BK_IDLE) begin
                illegal_nxt = 1'b1;
              end
            end
          end
        end
        SDC_CMD_REFRESH: begin
          // Refresh takes no row address from the pins; address pins are not read.
          if (both_idle) begin
            st_nxt[0] = SDC_BK_REFRESH;
            st_nxt[1] = SDC_BK_REFRESH;
            cnt_nxt[0] = cyc(SDC_CYC_ROW_CYCLE);
            cnt_nxt[1] = cyc(SDC_CYC_ROW_CYCLE);
          end else begin
            illegal_nxt = 1'b1;
          end
        end
        default: begin
          if (both_idle) begin
            cfg_nxt = pins_r.addr;
            st_nxt[0] = SDC_BK_CFG;
            st_nxt[1] = SDC_BK_CFG;
            cnt_nxt[0] = cyc(SDC_CYC_CFG_TO_CMD);
            cnt_nxt[1] = cyc(SDC_CYC_CFG_TO_CMD);
          end else begin
            illegal_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int b = 0; b < 2; b++) begin
        st_r[b] <= SDC_BK_IDLE;
        cnt_r[b] <= '0;
        burst_r[b] <= '0;
        ap_r[b] <= 1'b0;
      end
      cfg_r <= SDC_CFG_RESET;
      issue_r <= '0;
      illegal_r <= 1'b0;
      lowp_r <= 1'b0;
      gate_prev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      burst_r <= burst_nxt;
      ap_r <= ap_nxt;
      cfg_r <= cfg_nxt;
      issue_r <= issue_nxt;
      illegal_r <= illegal_nxt;
      lowp_r <= lowp_nxt;
      gate_prev_r <= pins_r.clk_gate;
    end
  end

  always_comb begin
    issue_out = issue_r;
    cfg_out = cfg_r;
    bank0_state_out = st_r[0];
    bank1_state_out = st_r[1];
    illegal_out = illegal_r;
    low_power_out = lowp_r;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  sequence open_seq;
    !lowp_r && cmd == SDC_CMD_ROW_OPEN && st_r[0] == SDC_BK_IDLE && !sel && pins_r.clk_gate && gate_prev_r;
  endsequence
  open_to_active_a: assert property (open_seq |=> st_r[0] == SDC_BK_OPENING ##1 st_r[0] == SDC_BK_ACTIVE)
    else $error("bank not active after row open");
  cfg_capture_a: assert property (!lowp_r && cmd == SDC_CMD_CFG_LOAD && both_idle && pins_r.clk_gate && gate_prev_r
    |=> cfg_r == $past(pins_r.addr))
    else $error("config not captured");
  refresh_busy_a: assert property (st_r[0] == SDC_BK_REFRESH && $past(st_r[0]) != SDC_BK_REFRESH && !lowp_r
    |-> st_r[0] == SDC_BK_REFRESH [*3] ##1 st_r[0] == SDC_BK_IDLE)
    else $error("refresh duration wrong");
  cfg_busy_a: assert property (st_r[1] == SDC_BK_CFG && $past(st_r[1]) != SDC_BK_CFG
    |-> st_r[1] == SDC_BK_CFG [*2] ##1 st_r[1] == SDC_BK_IDLE)
    else $error("config delay wrong");
  wrrec_exit_a: assert property (st_r[0] == SDC_BK_WR_REC && $past(st_r[0]) != SDC_BK_WR_REC && cmd != SDC_CMD_READ
    && cmd != SDC_CMD_STORE |=> st_r[0] == SDC_BK_ACTIVE)
    else $error("write recovery not ended");
  wrap_exit_a: assert property (st_r[0] == SDC_BK_WR_REC_AP && $past(st_r[0]) != SDC_BK_WR_REC_AP
    |-> st_r[0] == SDC_BK_WR_REC_AP [*2] ##1 st_r[0] == SDC_BK_IDLE)
    else $error("auto-precharge recovery wrong");
  bst_gate_a: assert property (issue_r.burst_stop |-> cfg_r[SDC_BL_LSB +: 3] == SDC_BL_FULL_PAGE)
    else $error("burst stop honoured outside full page");
  sleep_hold_a: assert property (lowp_r && !pins_r.clk_gate |=> lowp_r && $stable(cfg_r) && !illegal_r)
    else $error("inputs seen while asleep");
  pd_enter_a: assert property (!lowp_r && both_idle && gate_prev_r && !pins_r.clk_gate
    |=> lowp_r && st_r[0] != SDC_BK_IDLE)
    else $error("power-down not entered");
endmodule : sdc_cmd_state

// ### tb/sdc_ctrl_model.sv
`timescale 1ns/10ps
module sdc_ctrl_model
  import sdc_pkg::*;
(
  input wire logic clk_sys_in, // System clock.
  input wire logic req_in, // Send one command next edge.
  input wire logic [3:0] enc_in, // Command encoding.
  input wire logic [SDC_ADDR_W-1:0] addr_in, // Address, bank select on top.
  input wire logic gate_in, // Clock-gate level.
  output sdc_pins_s pins_out // Pins toward the device.
);
  sdc_pins_s pins_r;
  initial pins_r = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 12'h5A5};
  // Between commands only chip select is held; the other lines wander so nothing may lean on them.
  always @(posedge clk_sys_in) begin
    pins_r.clk_gate <= gate_in;
    if (req_in) begin
      {pins_r.chip_sel_n, pins_r.row_strobe_n, pins_r.col_strobe_n, pins_r.wr_en_n} <= enc_in;
      pins_r.addr <= addr_in;
    end else begin
      pins_r.chip_sel_n <= 1'b1;
      {pins_r.row_strobe_n, pins_r.col_strobe_n, pins_r.wr_en_n} <=
        ~{pins_r.row_strobe_n, pins_r.col_strobe_n, pins_r.wr_en_n};
      pins_r.addr <= ~pins_r.addr;
    end
  end
  assign pins_out = pins_r;
endmodule : sdc_ctrl_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import sdc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic req = 1'b0;
  logic [3:0] enc = SDC_ENC_NOP;
  logic [SDC_ADDR_W-1:0] addr = 12'h000;
  logic gate = 1'b1;
  sdc_pins_s pins;
  sdc_issue_s issue;
  logic [SDC_ADDR_W-1:0] cfg;
  sdc_bank_e bank0;
  sdc_bank_e bank1;
  logic illegal;
  logic low_power;
  int fails = 0;
  int checked = 0;
  int n_rd = 0;
  int n_st = 0;
  int n_bs = 0;
  int n_ill = 0;
  logic [10:0] last_col;
  always #12.5 clk_sys_in = ~clk_sys_in;
  sdc_ctrl_model sdc_ctrl_model_inst (.clk_sys_in(clk_sys_in), .req_in(req), .enc_in(enc), .addr_in(addr),
    .gate_in(gate), .pins_out(pins));
  sdc_cmd_state #(.BURST_LEN(4)) sdc_cmd_state_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .pins_in(pins), .issue_out(issue), .cfg_out(cfg), .bank0_state_out(bank0), .bank1_state_out(bank1),
    .illegal_out(illegal), .low_power_out(low_power));
  // ------------------------------------------------------------
  // Pulse monitor
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (illegal === 1'b1) n_ill++;
    if (issue.read_start === 1'b1) n_rd++;
    if (issue.store_start === 1'b1) n_st++;
    if (issue.burst_stop === 1'b1) n_bs++;
    if (issue.read_start === 1'b1 || issue.store_start === 1'b1) last_col = {issue.autopre, issue.bank, 1'b0, issue.col};
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    checked++;
    if (seen !== expd) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, expd);
    end
  endtask : check
  // Commands leave one idle cycle between them, enough after a row open but not after a config load or a refresh.
  task automatic cmd(input logic [3:0] e, input logic [11:0] a);
    @(posedge clk_sys_in);
    req <= 1'b1;
    enc <= e;
    addr <= a;
    @(posedge clk_sys_in);
    req <= 1'b0;
  endtask : cmd
  task automatic wait_for(input int which, input logic [31:0] val, input int lim);
    logic [31:0] cur;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_sys_in);
      cur = (which == 2) ? {31'h0, low_power} : (which == 1) ? bank1 : bank0;
      if (cur === val) begin
        checked++;
        return;
      end
    end
    fails++;
    $display("CHECK FAILED at %0t: wait on output %0d timed out", $time, which);
    conclude();
  endtask : wait_for
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    check(cfg, SDC_CFG_RESET, "cfg reset");
    check(bank0, SDC_BK_IDLE, "bank0 reset");
    check(bank1, SDC_BK_IDLE, "bank1 reset");
    check(low_power, 1'b0, "low power reset");
  endtask : s_reset
  task automatic s_cfg_guard();
    int ill;
    ill = n_ill;
    cmd(SDC_ENC_CFG_LOAD, 12'hA50);
    cmd(SDC_ENC_ROW_OPEN, 12'h000);
    repeat (6) @(posedge clk_sys_in);
    check(n_ill, ill + 1, "open during cfg load");
    check(bank0, SDC_BK_IDLE, "bank0 after refused open");
    check(cfg, 12'hA50, "cfg captured");
  endtask : s_cfg_guard
  task automatic s_open_read();
    int rd;
    int bs;
    rd = n_rd;
    bs = n_bs;
    cmd(SDC_ENC_ROW_OPEN, 12'h000);
    cmd(SDC_ENC_READ, 12'h3A5);
    cmd(SDC_ENC_BST, 12'h000);
    repeat (6) @(posedge clk_sys_in);
    check(n_rd, rd + 1, "read after open");
    check(last_col, 11'h0A5, "read column and bank");
    check(n_bs, bs, "burst stop outside full page");
    check(bank0, SDC_BK_ACTIVE, "bank0 active");
  endtask : s_open_read
  task automatic s_store_autopre();
    int st;
    st = n_st;
    cmd(SDC_ENC_ROW_OPEN, 12'h800);
    cmd(SDC_ENC_STORE, 12'hFFF);
    wait_for(1, SDC_BK_WR_REC_AP, 20);
    wait_for(1, SDC_BK_IDLE, 8);
    check(n_st, st + 1, "store issued");
    check(last_col, 11'h6FF, "store column, bank, autopre");
    check(bank0, SDC_BK_ACTIVE, "bank0 untouched");
  endtask : s_store_autopre
  task automatic s_full_page_stop();
    int bs;
    bs = n_bs;
    cmd(SDC_ENC_ROW_CLOSE, 12'h400);
    wait_for(0, SDC_BK_IDLE, 8);
    cmd(SDC_ENC_CFG_LOAD, 12'h007);
    cmd(SDC_ENC_NOP, 12'h000);
    cmd(SDC_ENC_ROW_OPEN, 12'h000);
    cmd(SDC_ENC_STORE, 12'h010);
    cmd(SDC_ENC_BST, 12'h000);
    repeat (6) @(posedge clk_sys_in);
    check(n_bs, bs + 1, "burst stop in full page");
    cmd(SDC_ENC_ROW_CLOSE, 12'h400);
    wait_for(0, SDC_BK_IDLE, 20);
  endtask : s_full_page_stop
  task automatic s_refresh_guard();
    int ill;
    ill = n_ill;
    cmd(SDC_ENC_REFRESH, 12'hABC);
    cmd(SDC_ENC_READ, 12'h000);
    wait_for(0, SDC_BK_REFRESH, 8);
    wait_for(0, SDC_BK_IDLE, 8);
    check(n_ill, ill + 1, "read during refresh");
    check(cfg, 12'h007, "cfg kept by refresh");
  endtask : s_refresh_guard
  task automatic s_low_power();
    int ill;
    ill = n_ill;
    @(posedge clk_sys_in);
    gate <= 1'b0;
    wait_for(2, 1'b1, 8);
    cmd(SDC_ENC_ROW_OPEN, 12'h000);
    repeat (5) @(posedge clk_sys_in);
    check(n_ill, ill, "inputs ignored in power-down");
    check(low_power, 1'b1, "still in power-down");
    gate <= 1'b1;
    wait_for(2, 1'b0, 8);
    wait_for(0, SDC_BK_IDLE, 8);
    @(posedge clk_sys_in);
    gate <= 1'b0;
    req <= 1'b1;
    enc <= SDC_ENC_REFRESH;
    @(posedge clk_sys_in);
    req <= 1'b0;
    wait_for(0, SDC_BK_RETAIN, 8);
    cmd(SDC_ENC_CFG_LOAD, 12'hFFF);
    repeat (5) @(posedge clk_sys_in);
    check(cfg, 12'h007, "cfg ignored in retention");
    gate <= 1'b1;
    wait_for(2, 1'b0, 8);
  endtask : s_low_power
  // Bank 0 goes through plain write recovery and recovery with auto-precharge.
  // The read is timed to land in the single recovery cycle, so the burst is over and the bus has turned around.
  task automatic s_write_recovery();
    int rd;
    int st;
    int ill;
    rd = n_rd;
    st = n_st;
    ill = n_ill;
    cmd(SDC_ENC_CFG_LOAD, 12'h000);
    cmd(SDC_ENC_NOP, 12'h000);
    cmd(SDC_ENC_ROW_OPEN, 12'h000);
    cmd(SDC_ENC_STORE, 12'h000);
    wait_for(0, SDC_BK_WR_REC, 12);
    wait_for(0, SDC_BK_ACTIVE, 4);
    cmd(SDC_ENC_STORE, 12'h000);
    repeat (3) @(posedge clk_sys_in);
    cmd(SDC_ENC_READ, 12'h000);
    repeat (3) @(posedge clk_sys_in);
    check(bank0, SDC_BK_WR_REC, "read decoded in write recovery");
    cmd(SDC_ENC_STORE, 12'h400);
    wait_for(0, SDC_BK_WR_REC_AP, 12);
    wait_for(0, SDC_BK_IDLE, 6);
    check(n_rd, rd + 1, "read started from recovery");
    check(n_st, st + 3, "stores issued");
    check(n_ill, ill, "no illegal in recovery");
  endtask : s_write_recovery
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    s_reset();
    s_cfg_guard();
    s_open_read();
    s_store_autopre();
    s_full_page_stop();
    s_refresh_guard();
    s_low_power();
    s_write_recovery();
    conclude();
  end
endmodule : testbench
